// ==== spi_rap_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_rap_chk (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_csb_n,
    input wire logic i_si,
    input wire logic i_so,
    input wire logic i_so_oe,
    input wire logic i_so_line
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    idle_clk_low_a: assert property (i_csb_n |-> !i_sclk) else $error("sclk high outside frame");
    si_at_rise_a: assert property ($rose(i_sclk) |-> $stable(i_si)) else $error("si moved at sclk rise");
    si_move_low_a: assert property ($changed(i_si) |-> !i_sclk) else $error("si moved while sclk high");
    sclk_high_width_a: assert property ($rose(i_sclk) |=> i_sclk [*8]) else $error("short sclk high");
    sclk_low_width_a: assert property ($fell(i_sclk) && !i_csb_n |=> !i_sclk [*8]) else $error("short sclk low");
    frame_gap_a: assert property ($rose(i_csb_n) |=> i_csb_n [*8]) else $error("short select gap");
    oe_start_a: assert property ($fell(i_csb_n) |-> ##[1:6] i_so_oe) else $error("status not driven");
    oe_release_a: assert property ($rose(i_csb_n) |-> ##[1:6] !i_so_oe) else $error("so not released");
    so_hold_a: assert property (i_sclk && $past(i_sclk) |-> $stable(i_so)) else $error("so moved while sclk high");
    cover property ($fell(i_csb_n));
    cover property ($rose(i_so_oe) ##[1:20] $rose(i_sclk));
    cover property (i_so_oe && !i_so_line);
endmodule
`default_nettype wire

// ==== spi_rap_device.sv ====
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`default_nettype none
`include "spi_rap_params.svh"
module spi_rap_device
    import spi_rap_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    spi_rap_if.device link,
    input wire logic i_integrity_test_flag,
    input wire logic i_failure_summary_flag,
    input wire logic i_latched_shutdown,
    input wire logic i_nvm_busy_flag,
    input wire logic [2:0] i_operating_state_code,
    input wire logic i_main_write_lock,
    input wire logic i_nvm_write_lock,
    input wire logic [15:0] i_base_pointer_reg,
    output logic [15:0] o_acc_addr,
    input wire logic [7:0] i_acc_rd_data,
    input wire logic i_acc_defined,
    input wire logic i_acc_read_only,
    input wire acc_kind_e i_acc_kind,
    output logic o_wr_en,
    output logic [15:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic o_access_failed_flag
);

    typedef struct packed {
        dev_state_e st;
        logic sclk_m, sclk_s, sclk_p;
        logic csb_m, csb_s, csb_p;
        logic si_m, si_s, si_p;
        logic [2:0] bitcnt;
        logic [3:0] bytecnt;
        logic [7:0] hdr;
        logic [15:0] addr;
        logic [7:0] rxsh;
        logic [7:0] tx;
        logic [7:0] rx_crc;
        logic [7:0] tx_crc;
        logic crc_ok;
        logic err;
        logic failed;
        logic so_oe;
        logic [7:0][7:0] wbuf;
        logic [3:0] wcnt;
        logic wr_en;
        logic [15:0] wr_addr;
        logic [7:0] wr_data;
    } dev_s;

    dev_s r_ff;
    dev_s nxt_r;

    function automatic logic [15:0] base_addr(input logic [3:0] sel, input logic [15:0] ptr);
        case (sel)
            4'h1: base_addr = `BASE_ADDR_1;
            4'h2: base_addr = `BASE_ADDR_2;
            4'h3: base_addr = `BASE_ADDR_3;
            4'h4: base_addr = `BASE_ADDR_4;
            4'h5: base_addr = `BASE_ADDR_5;
            4'h6: base_addr = `BASE_ADDR_6;
            4'h7: base_addr = `BASE_ADDR_7;
            4'h8: base_addr = `BASE_ADDR_8;
            4'h9: base_addr = `BASE_ADDR_9;
            4'ha: base_addr = `BASE_ADDR_10;
            4'hb: base_addr = `BASE_ADDR_11;
            4'hc: base_addr = `BASE_ADDR_12;
            4'hd: base_addr = `BASE_ADDR_13;
            4'he: base_addr = `BASE_ADDR_14;
            4'hf: base_addr = ptr;
            default: base_addr = 16'h0000;
        endcase
    endfunction

    logic wr_mode;
    logic [3:0] sel;
    logic [3:0] nadr;
    logic [3:0] ndata;
    logic [3:0] crc_idx;
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    logic [7:0] b;
    logic [7:0] d;
    logic acc_err;
    logic end_err;

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        wr_mode = r_ff.hdr[`HDR_RW_BIT];
        sel = r_ff.hdr[`HDR_BASE_MSB:`HDR_BASE_LSB];
        nadr = (sel == `BASE_FULL) ? 4'h2 : 4'h0;
        ndata = {1'b0, r_ff.hdr[`HDR_LEN_MSB:`HDR_LEN_LSB]} + 4'h1;
        crc_idx = nadr + ndata + 4'h1;
        rise = r_ff.sclk_s & ~r_ff.sclk_p;
        fall = ~r_ff.sclk_s & r_ff.sclk_p;
        cs_fall = r_ff.csb_p & ~r_ff.csb_s;
        cs_rise = ~r_ff.csb_p & r_ff.csb_s;
        b = {r_ff.rxsh[6:0], r_ff.si_s};
        d = 8'h00;
        end_err = 1'b0;

        // Checks on the register that the current data byte reaches
        acc_err = ~i_acc_defined;
        if ((i_acc_kind == KIND_MAIN_BUSY || i_acc_kind == KIND_NVM) && i_nvm_busy_flag) begin
            acc_err = 1'b1;
        end
        if (wr_mode) begin
            if (i_acc_read_only) begin
                acc_err = 1'b1;
            end
            if (i_acc_kind == KIND_NVM_DATA && i_nvm_busy_flag) begin
                acc_err = 1'b1;
            end
            if ((i_acc_kind == KIND_MAIN || i_acc_kind == KIND_MAIN_BUSY) && i_main_write_lock) begin
                acc_err = 1'b1;
            end
            if ((i_acc_kind == KIND_NVM || i_acc_kind == KIND_NVM_DATA) && i_nvm_write_lock) begin
                acc_err = 1'b1;
            end
        end

        nxt_r = r_ff;
        nxt_r.sclk_m = link.sclk;
        nxt_r.sclk_s = r_ff.sclk_m;
        nxt_r.sclk_p = r_ff.sclk_s;
        nxt_r.csb_m = link.csb_n;
        nxt_r.csb_s = r_ff.csb_m;
        nxt_r.csb_p = r_ff.csb_s;
        nxt_r.si_m = link.si;
        nxt_r.si_s = r_ff.si_m;
        nxt_r.si_p = r_ff.si_s;
        nxt_r.wr_en = 1'b0;

        case (r_ff.st)
            DV_IDLE: begin
                if (cs_fall) begin
                    nxt_r.st = DV_FRAME;
                    nxt_r.bitcnt = 3'd0;
                    nxt_r.bytecnt = 4'd0;
                    nxt_r.hdr = 8'h00;
                    nxt_r.err = 1'b0;
                    nxt_r.crc_ok = 1'b0;
                    nxt_r.rx_crc = `CRC_SEED;
                    nxt_r.so_oe = 1'b1;
                    d[`GS_INTEGRITY] = i_integrity_test_flag;
                    d[`GS_ACC_FAIL] = r_ff.failed;
                    d[`GS_FAIL_SUM] = i_failure_summary_flag;
                    d[`GS_LATCH] = i_latched_shutdown;
                    d[`GS_BUSY] = i_nvm_busy_flag;
                    d[2:0] = i_operating_state_code;
                    nxt_r.tx = d;
                    nxt_r.tx_crc = crc8_byte(`CRC_SEED, d);
                end
            end
            DV_FRAME: begin
                if (rise) begin
                    nxt_r.rxsh = b;
                    nxt_r.bitcnt = r_ff.bitcnt + 3'd1;
                    if (r_ff.si_s != r_ff.si_p) begin
                        nxt_r.err = 1'b1;
                    end
                    if (r_ff.bitcnt == 3'd7) begin
                        if (r_ff.bytecnt != 4'hf) begin
                            nxt_r.bytecnt = r_ff.bytecnt + 4'd1;
                        end
                        if (r_ff.bytecnt < crc_idx) begin
                            nxt_r.rx_crc = crc8_byte(r_ff.rx_crc, b);
                        end
                        if (r_ff.bytecnt == 4'd0) begin
                            nxt_r.hdr = b;
                            nxt_r.addr = base_addr(b[`HDR_BASE_MSB:`HDR_BASE_LSB], i_base_pointer_reg);
                        end else if (r_ff.bytecnt <= nadr) begin
                            if (r_ff.bytecnt == 4'd1) begin
                                nxt_r.addr[15:8] = b;
                            end else begin
                                nxt_r.addr[7:0] = b;
                            end
                        end else if (r_ff.bytecnt < crc_idx) begin
                            nxt_r.wbuf[3'(r_ff.bytecnt - nadr - 4'd1)] = b;
                            nxt_r.addr = r_ff.addr + 16'h0001;
                            if (acc_err) begin
                                nxt_r.err = 1'b1;
                            end
                        end else if (r_ff.bytecnt == crc_idx) begin
                            nxt_r.crc_ok = (b == r_ff.rx_crc);
                        end else begin
                            nxt_r.err = 1'b1;
                        end
                    end
                end
                if (fall) begin
                    if (r_ff.bitcnt == 3'd0 && r_ff.bytecnt != 4'd0) begin
                        if (r_ff.bytecnt == crc_idx) begin
                            d = r_ff.tx_crc;
                        end else if (r_ff.bytecnt > nadr && r_ff.bytecnt < crc_idx && !wr_mode) begin
                            d = i_acc_rd_data;
                        end
                        nxt_r.tx = d;
                        nxt_r.tx_crc = crc8_byte(r_ff.tx_crc, d);
                    end else begin
                        nxt_r.tx = {r_ff.tx[6:0], 1'b0};
                    end
                end
                if (cs_rise) begin
                    // Partial bytes or a short frame break the 8-bit byte framing
                    end_err = r_ff.err | (r_ff.bitcnt != 3'd0) | (r_ff.bytecnt != crc_idx + 4'd1);
                    nxt_r.failed = end_err | ~r_ff.crc_ok;
                    nxt_r.so_oe = 1'b0;
                    nxt_r.wcnt = 4'd0;
                    nxt_r.st = (!end_err && r_ff.crc_ok && wr_mode) ? DV_COMMIT : DV_IDLE;
                end
            end
            DV_COMMIT: begin
                // Writes land only after the whole frame proved clean
                nxt_r.wr_en = 1'b1;
                nxt_r.wr_addr = r_ff.addr - {12'h000, ndata} + {12'h000, r_ff.wcnt};
                nxt_r.wr_data = r_ff.wbuf[r_ff.wcnt[2:0]];
                nxt_r.wcnt = r_ff.wcnt + 4'd1;
                if (r_ff.wcnt + 4'd1 == ndata) begin
                    nxt_r.st = DV_IDLE;
                end
            end
            default: nxt_r.st = DV_IDLE;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            r_ff <= '0;
            r_ff.st <= DV_IDLE;
            r_ff.csb_m <= 1'b1;
            r_ff.csb_s <= 1'b1;
            r_ff.csb_p <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign link.so = r_ff.tx[7];
    assign link.so_oe = r_ff.so_oe;
    assign o_acc_addr = r_ff.addr;
    assign o_wr_en = r_ff.wr_en;
    assign o_wr_addr = r_ff.wr_addr;
    assign o_wr_data = r_ff.wr_data;
    assign o_access_failed_flag = r_ff.failed;

endmodule
`default_nettype wire

// ==== spi_rap_host.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "spi_rap_params.svh"
module spi_rap_host
    import spi_rap_pkg::*;
#(
    parameter int HALF_CYC = `SCLK_HALF_CYC,
    parameter int GAP_CYC = `CS_HIGH_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    spi_rap_if.host link,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);

    typedef struct packed {
        host_state_e st;
        logic [15:0] cnt;
        logic [6:0] bitcnt;
        logic [6:0] nbits;
        logic [95:0] txsh;
        logic [95:0] rxsh;
        logic [7:0] hdr;
        logic [15:0] addr;
        logic [7:0][7:0] wdata;
        logic so_m, so_s;
        logic sclk, csb_n, si;
        logic rvalid;
        logic [31:0] rdata;
    } host_s;

    host_s r_ff;
    host_s nxt_r;

    logic [11:0][7:0] fb;
    logic [11:0][7:0] rb;
    logic [95:0] rxa;
    logic [95:0] fa;
    logic [3:0] nadr;
    logic [3:0] total;
    logic [7:0] crc;
    logic [7:0] rcrc;
    logic rx_ok;
    logic [3:0] ri;

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        // Frame image: header, optional address, data or dummies, check byte
        nadr = (r_ff.hdr[`HDR_BASE_MSB:`HDR_BASE_LSB] == `BASE_FULL) ? 4'h2 : 4'h0;
        total = nadr + {1'b0, r_ff.hdr[`HDR_LEN_MSB:`HDR_LEN_LSB]} + 4'h3;
        crc = `CRC_SEED;
        fb = '0;
        fa = '0;
        for (int k = 0; k < 12; k++) begin
            if (k == 0) begin
                fb[k] = r_ff.hdr;
            end else if (4'(k) <= nadr) begin
                fb[k] = (k == 1) ? r_ff.addr[15:8] : r_ff.addr[7:0];
            end else if (4'(k) < total - 4'h1) begin
                fb[k] = r_ff.hdr[`HDR_RW_BIT] ? r_ff.wdata[3'(4'(k) - nadr - 4'h1)] : 8'h00;
            end else if (4'(k) == total - 4'h1) begin
                fb[k] = crc;
            end
            if (4'(k) < total - 4'h1) begin
                crc = crc8_byte(crc, fb[k]);
            end
            fa[95 - 8 * k -: 8] = fb[k];
        end
        // Received bytes, first at the top; answer checked with its own CRC
        rxa = r_ff.rxsh << (7'd96 - r_ff.nbits);
        rcrc = `CRC_SEED;
        rx_ok = 1'b0;
        for (int k = 0; k < 12; k++) begin
            rb[k] = rxa[95 - 8 * k -: 8];
            if (4'(k) < total - 4'h1) begin
                rcrc = crc8_byte(rcrc, rb[k]);
            end else if (4'(k) == total - 4'h1) begin
                rx_ok = (rcrc == rb[k]);
            end
        end
        ri = 4'(i_avs_address[5:2]);

        nxt_r = r_ff;
        nxt_r.so_m = link.so_line;
        nxt_r.so_s = r_ff.so_m;
        nxt_r.cnt = r_ff.cnt + 16'd1;

        // Bus slave: writes take one cycle, reads one wait state
        nxt_r.rvalid = i_avs_read & ~r_ff.rvalid;
        if (i_avs_read && !r_ff.rvalid) begin
            nxt_r.rdata = 32'h0000_0000;
            if (i_avs_address == `HREG_CMD) begin
                nxt_r.rdata = {24'h000000, r_ff.hdr};
            end else if (i_avs_address == `HREG_ADDR) begin
                nxt_r.rdata = {16'h0000, r_ff.addr};
            end else if (i_avs_address == `HREG_STAT) begin
                nxt_r.rdata = {16'h0000, rb[0], 6'h00, rx_ok, r_ff.st != HS_IDLE};
            end else if (i_avs_address[7:5] == 3'b001 && i_avs_address[4:2] <= 3'd7) begin
                nxt_r.rdata = {24'h000000, r_ff.wdata[i_avs_address[4:2]]};
            end else if (i_avs_address[7:6] == 2'b01 && ri < 4'd12) begin
                nxt_r.rdata = {24'h000000, rb[ri]};
            end
        end
        if (i_avs_write && r_ff.st == HS_IDLE) begin
            if (i_avs_address == `HREG_ADDR) begin
                nxt_r.addr = i_avs_writedata[15:0];
            end else if (i_avs_address[7:5] == 3'b001) begin
                nxt_r.wdata[i_avs_address[4:2]] = i_avs_writedata[7:0];
            end else if (i_avs_address == `HREG_CMD) begin
                nxt_r.hdr = i_avs_writedata[7:0];
                nxt_r.st = HS_SETUP;
                nxt_r.cnt = 16'd0;
                nxt_r.rxsh = '0;
            end
        end

        case (r_ff.st)
            HS_IDLE: begin
                nxt_r.csb_n = 1'b1;
                nxt_r.sclk = 1'b0;
            end
            HS_SETUP: begin
                if (r_ff.cnt == 16'd0) begin
                    // Header at the top, since the shifter leaves from bit 95
                    nxt_r.txsh = fa;
                    nxt_r.nbits = {total, 3'b000};
                    nxt_r.bitcnt = 7'd0;
                    nxt_r.csb_n = 1'b0;
                    nxt_r.si = fb[0][7];
                end else if (r_ff.cnt >= 16'(HALF_CYC)) begin
                    nxt_r.st = HS_HIGH;
                    nxt_r.sclk = 1'b1;
                    nxt_r.cnt = 16'd0;
                    nxt_r.rxsh = {r_ff.rxsh[94:0], r_ff.so_s};
                end
            end
            HS_HIGH: begin
                if (r_ff.cnt >= 16'(HALF_CYC - 1)) begin
                    // SI moves only with the falling edge, except the first bit, set as select falls
                    nxt_r.sclk = 1'b0;
                    nxt_r.cnt = 16'd0;
                    nxt_r.txsh = {r_ff.txsh[94:0], 1'b0};
                    nxt_r.si = r_ff.txsh[94];
                    nxt_r.bitcnt = r_ff.bitcnt + 7'd1;
                    nxt_r.st = (r_ff.bitcnt + 7'd1 == r_ff.nbits) ? HS_HOLD : HS_LOW;
                end
            end
            HS_LOW: begin
                if (r_ff.cnt >= 16'(HALF_CYC - 1)) begin
                    nxt_r.st = HS_HIGH;
                    nxt_r.sclk = 1'b1;
                    nxt_r.cnt = 16'd0;
                    nxt_r.rxsh = {r_ff.rxsh[94:0], r_ff.so_s};
                end
            end
            HS_HOLD: begin
                if (r_ff.cnt >= 16'(HALF_CYC - 1)) begin
                    nxt_r.csb_n = 1'b1;
                    nxt_r.si = 1'b0;
                    nxt_r.cnt = 16'd0;
                    nxt_r.st = HS_GAP;
                end
            end
            HS_GAP: begin
                if (r_ff.cnt >= 16'(GAP_CYC - 1)) begin
                    nxt_r.st = HS_IDLE;
                end
            end
            default: nxt_r.st = HS_IDLE;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            r_ff <= '0;
            r_ff.st <= HS_IDLE;
            r_ff.csb_n <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign link.sclk = r_ff.sclk;
    assign link.csb_n = r_ff.csb_n;
    assign link.si = r_ff.si;
    assign o_avs_readdata = r_ff.rdata;
    assign o_avs_waitrequest = i_avs_read & ~r_ff.rvalid;

endmodule
`default_nettype wire

// ==== spi_rap_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface spi_rap_if;
    logic sclk;
    logic csb_n;
    logic si;
    logic so;
    logic so_oe;
    wire so_line;
    // Pulled up while the device leaves the output floating
    assign so_line = so_oe ? so : 1'b1;
    modport device (input sclk, input csb_n, input si, input so_line, output so, output so_oe);
    modport host (output sclk, output csb_n, output si, input so_line, input so_oe);
endinterface
`default_nettype wire

// ==== spi_rap_params.svh ====
`ifndef SPI_RAP_PARAMS_SVH
`define SPI_RAP_PARAMS_SVH
// Timing
`define CLK_PERIOD_NS 5
`define T_SCLK_HALF_NS 950
`define T_CS_HIGH_NS 1900
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_HALF_CYC `CYC_MIN(`T_SCLK_HALF_NS)
`define CS_HIGH_CYC `CYC_MIN(`T_CS_HIGH_NS)
// Header fields
`define HDR_RW_BIT 7
`define HDR_LEN_MSB 6
`define HDR_LEN_LSB 4
`define HDR_BASE_MSB 3
`define HDR_BASE_LSB 0
`define BASE_FULL 4'h0
`define BASE_POINTER 4'hf
// Check byte
`define CRC_POLY 8'h4d
`define CRC_SEED 8'h00
// Status byte positions
`define GS_INTEGRITY 7
`define GS_ACC_FAIL 6
`define GS_FAIL_SUM 5
`define GS_LATCH 4
`define GS_BUSY 3
// Preset base addresses
`define BASE_ADDR_1 16'h0000
`define BASE_ADDR_2 16'h0002
`define BASE_ADDR_3 16'h0003
`define BASE_ADDR_4 16'h0005
`define BASE_ADDR_5 16'h0009
`define BASE_ADDR_6 16'h000c
`define BASE_ADDR_7 16'h000d
`define BASE_ADDR_8 16'h0015
`define BASE_ADDR_9 16'h0201
`define BASE_ADDR_10 16'h0205
`define BASE_ADDR_11 16'h0300
`define BASE_ADDR_12 16'h0301
`define BASE_ADDR_13 16'h0303
`define BASE_ADDR_14 16'h0306
// Controller register byte offsets
`define HREG_CMD 8'h00
`define HREG_ADDR 8'h04
`define HREG_STAT 8'h08
`define HREG_WDATA 8'h20
`define HREG_RDATA 8'h40
`endif

// ==== spi_rap_pkg.sv ====
`default_nettype none
`include "spi_rap_params.svh"
package spi_rap_pkg;
    typedef enum logic [2:0] {
        KIND_FREE,
        KIND_MAIN,
        KIND_MAIN_BUSY,
        KIND_NVM,
        KIND_NVM_DATA
    } acc_kind_e;

    typedef enum {DV_IDLE, DV_FRAME, DV_COMMIT} dev_state_e;
    typedef enum {HS_IDLE, HS_SETUP, HS_HIGH, HS_LOW, HS_HOLD, HS_GAP} host_state_e;

    function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "spi_rap_params.svh"
module tb_top
    import spi_rap_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] av_a = 8'h00;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] av_q;
    logic av_wait;
    logic [7:0] gsv = 8'h02;
    logic lock_m = 1'b0;
    logic lock_nvm = 1'b0;
    logic [15:0] bptr = 16'h0000;
    logic [15:0] acc_a;
    logic [15:0] wr_a;
    logic [7:0] wr_d;
    logic [7:0] rd_b;
    logic wr_en;
    logic acc_fail;
    acc_kind_e kind;
    int fail_count = 0;
    int num_checks = 0;
    logic [15:0] wa[$];
    logic [7:0] wd[$];
    // Small register file: access-check bytes, 4 KiB defined space
    assign rd_b = acc_a == 16'h0 ? 8'h55 : acc_a == 16'h1 ? 8'haa : acc_a[7:0];
    assign kind = acc_a[11] ? KIND_NVM : acc_a[9] ? KIND_MAIN : KIND_FREE;
    always #2.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (wr_en === 1'b1) begin
        wa.push_back(wr_a);
        wd.push_back(wr_d);
    end
    spi_rap_if lnk();
    spi_rap_device i_spi_rap_device(.i_clk_sys, .i_rst, .link(lnk), .i_integrity_test_flag(gsv[7]),
        .i_failure_summary_flag(gsv[5]), .i_latched_shutdown(gsv[4]), .i_nvm_busy_flag(gsv[3]),
        .i_operating_state_code(gsv[2:0]), .i_main_write_lock(lock_m), .i_nvm_write_lock(lock_nvm),
        .i_base_pointer_reg(bptr), .o_acc_addr(acc_a), .i_acc_rd_data(rd_b), .i_acc_defined(acc_a < 16'h1000),
        .i_acc_read_only(acc_a < 16'h0002), .i_acc_kind(kind), .o_wr_en(wr_en), .o_wr_addr(wr_a),
        .o_wr_data(wr_d), .o_access_failed_flag(acc_fail));
    spi_rap_host #(.HALF_CYC(16), .GAP_CYC(16)) i_spi_rap_host(.i_clk_sys, .i_rst, .link(lnk),
        .i_avs_address(av_a), .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
        .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait));
    spi_rap_chk i_spi_rap_chk(.i_clk_sys, .i_rst, .i_sclk(lnk.sclk), .i_csb_n(lnk.csb_n), .i_si(lnk.si),
        .i_so(lnk.so), .i_so_oe(lnk.so_oe), .i_so_line(lnk.so_line));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Held until waitrequest is sampled low at a rising edge; read data taken at that edge
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        av_a <= a;
        av_wd <= d;
        av_rd <= rd;
        av_wr <= !rd;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (av_wait !== 1'b0 && n < 50);
        q = av_q;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic rd8(input logic [7:0] a, output logic [15:0] v);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, q);
        v = {8'h00, q[7:0]};
    endtask
    task automatic frame(input logic [7:0] hdr);
        logic [31:0] q;
        int n;
        n = 0;
        wa.delete();
        wd.delete();
        bus(1'b0, `HREG_CMD, {24'h0, hdr}, q);
        do begin
            bus(1'b1, `HREG_STAT, 32'h0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            fail_count++;
            final_report();
        end
        // Commit lands a few cycles after select rises
        repeat (8) @(posedge i_clk_sys);
    endtask
    task automatic s_write_full();
        logic [31:0] q;
        logic [15:0] v;
        gsv <= 8'hb9;
        bus(1'b0, `HREG_ADDR, 32'h0301, q);
        bus(1'b0, `HREG_WDATA, 32'hc4, q);
        bus(1'b0, `HREG_WDATA + 8'h04, 32'h03, q);
        frame(8'h90);
        chk("write count", 16'h2, 16'(wa.size()));
        chk("addr 0", 16'h0301, wa[0]);
        chk("data 0", 16'hc4, wd[0]);
        chk("addr 1", 16'h0302, wa[1]);
        chk("data 1", 16'h03, wd[1]);
        rd8(`HREG_RDATA, v);
        chk("status", 16'hb9, v);
        bus(1'b1, `HREG_STAT, 32'h0, q);
        chk("crc ok", 16'h1, {15'h0, q[1]});
    endtask
    task automatic s_read_base();
        logic [15:0] v;
        gsv <= 8'h02;
        frame(8'h11);
        chk("no writes", 16'h0, 16'(wa.size()));
        rd8(`HREG_RDATA, v);
        chk("status", 16'h02, v);
        rd8(`HREG_RDATA + 8'h04, v);
        chk("read 0", 16'h55, v);
        rd8(`HREG_RDATA + 8'h08, v);
        chk("read 1", 16'haa, v);
        rd8(`HREG_RDATA + 8'h0c, v);
        chk("dev crc", 16'hb3, v);
    endtask
    task automatic s_lock();
        logic [31:0] q;
        logic [15:0] v;
        lock_m <= 1'b1;
        bptr <= 16'h0301;
        bus(1'b0, `HREG_WDATA, 32'h5a, q);
        frame(8'h9f);
        chk("locked writes", 16'h0, 16'(wa.size()));
        chk("fail flag", 16'h1, {15'h0, acc_fail});
        frame(8'h11);
        rd8(`HREG_RDATA, v);
        chk("status fail", 16'h42, v);
        lock_m <= 1'b0;
        // Count code zero: one register at the preset base
        frame(8'h8c);
        chk("short write", 16'h1, 16'(wa.size()));
        chk("short addr", 16'h0301, wa[0]);
        chk("short data", 16'h5a, wd[0]);
        chk("fail clear", 16'h0, {15'h0, acc_fail});
    endtask
    task automatic s_bad_access();
        logic [31:0] q;
        bus(1'b0, `HREG_ADDR, 32'h7000, q);
        frame(8'h00);
        chk("undefined", 16'h1, {15'h0, acc_fail});
        bus(1'b0, `HREG_ADDR, 32'h0000, q);
        frame(8'h80);
        chk("ro writes", 16'h0, 16'(wa.size()));
        chk("ro fail", 16'h1, {15'h0, acc_fail});
    endtask
    // Nonvolatile-side register: busy gates any access, its own lock gates writes
    task automatic s_nvm_gate();
        logic [31:0] q;
        gsv <= 8'h0a;
        bus(1'b0, `HREG_ADDR, 32'h0800, q);
        frame(8'h00);
        chk("busy read", 16'h1, {15'h0, acc_fail});
        gsv <= 8'h02;
        frame(8'h00);
        chk("idle read", 16'h0, {15'h0, acc_fail});
        lock_nvm <= 1'b1;
        frame(8'h80);
        chk("nvm writes", 16'h0, 16'(wa.size()));
        chk("nvm lock", 16'h1, {15'h0, acc_fail});
        lock_nvm <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        s_write_full();
        s_read_base();
        s_lock();
        s_bad_access();
        s_nvm_gate();
        final_report();
    end
endmodule
`default_nettype wire
